// File: src/tdm_port_timing.sv
`timescale 1ns/1ps
`include "tdm_timing_defines.svh"

// Notes on behaviour
// - discriminator off after reset, enable bit controls
// - mode 000 low jitter, 111 full
// - mode field ignored while enable low
// - default sampling point three quarters bit
// - per-stream input delay in quarter bits
// - sample mode low: field is quarter delay
// - sample mode high: low bits pick point
// - sample mode high: upper bits whole-bit delay
// - outputs advanced zero to three core cycles
// - mode select low: always driven bi-state
// - mode select high: disabled channel high-Z
// - mode selects captured during reset
// - enable priority reset, drive, standby, channel
module tdm_port_timing (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_reset,
  // register port
  input wire logic [7:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [15:0] o_rdata,
  // frame and pins (asynchronous)
  input wire logic i_master_frame_pulse,
  input wire logic i_output_drive_input,
  input wire logic i_local_output_mode_select,
  input wire logic i_backplane_output_mode_select,
  // per-channel enables from the connection memories
  input wire logic [7:0] i_local_channel_output_enable,
  input wire logic [7:0] i_backplane_channel_output_enable,
  // discriminator control
  output logic o_disc_active,
  output logic o_disc_high_freq,
  // per-stream input timing, packed 8 x 3 bits / 8 x 2 bits
  output logic [23:0] o_local_whole_delay,
  output logic [15:0] o_local_quarter_delay,
  output logic [23:0] o_backplane_whole_delay,
  output logic [15:0] o_backplane_quarter_delay,
  // per-stream output advance in core cycles
  output logic [15:0] o_local_advance,
  output logic [15:0] o_backplane_advance,
  // output enables: low while driving; level when not driving
  output logic [7:0] o_local_output_streams_oe_n,
  output logic [7:0] o_local_force_high,
  output logic [7:0] o_backplane_output_streams_oe_n,
  output logic [7:0] o_backplane_force_high
);

  ////////////////////////////////////////////////////////////////////////
  // declarations
  logic [15:0] control_reg; // control register
  logic [4:0] local_input_delay_reg [8]; // local input delay shadow
  logic [4:0] backplane_input_delay_reg [8]; // backplane delay shadow
  logic [1:0] local_output_advance_reg [8]; // local advance shadow
  logic [1:0] backplane_output_advance_reg [8]; // backplane advance shadow
  logic [15:0] rdata_next; // read mux result
  logic fp_meta_reg; // frame pulse sync stage 1
  logic fp_sync_reg; // frame pulse sync stage 2
  logic fp_prev_reg; // for edge detect
  logic drive_meta_reg; // drive-input sync stage 1
  logic drive_sync_reg; // drive-input sync stage 2
  logic lms_meta_reg; // local mode select sync
  logic lms_sync_reg;
  logic bms_meta_reg; // backplane mode select sync
  logic bms_sync_reg;
  logic local_tristate_mode_reg; // captured local mode select
  logic backplane_tristate_mode_reg; // captured backplane mode select
  logic frame_edge; // one-cycle frame boundary
  tdm_timing_pkg::disc_state_t disc_state;
  stream_timing_if lcfg ();
  stream_timing_if bcfg ();

  ////////////////////////////////////////////////////////////////////////
  // functions

  // true delay in quarter bits from a field and the sample mode
  function automatic logic [4:0] quarter_total(input logic [4:0] f,
                                               input logic smode);
    logic [4:0] q;
    q = 5'h00;
    if (!smode) begin
      q = f;
    end else begin
      q = {f[4:2], 2'h0};
    end
    return q;
  endfunction

  // sampling point code; in fractional mode the default 3/4 point is held
  function automatic logic [1:0] sample_point(input logic [4:0] f,
                                              input logic smode);
    return smode ? f[1:0] : `SAMPLE_3Q;
  endfunction

  // whole-bit part of a delay field; a function result cannot be
  // part-selected directly, so the slice is taken here
  function automatic logic [2:0] whole_bits(input logic [4:0] f,
                                            input logic smode);
    logic [4:0] q;
    q = quarter_total(f, smode);
    return q[4:2];
  endfunction

  // output enable per stream: high = drive data; a low channel enable
  // idles the stream in both port modes, only the idle level differs
  function automatic logic drive_ok(input logic drv, input logic stby,
                                    input logic ch_en);
    return drv & stby & ch_en;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // synchronisers for asynchronous pins
  always_ff @(posedge i_ref_clk) begin
    fp_meta_reg <= i_master_frame_pulse;
    fp_sync_reg <= fp_meta_reg;
    drive_meta_reg <= i_output_drive_input;
    drive_sync_reg <= drive_meta_reg;
    lms_meta_reg <= i_local_output_mode_select;
    lms_sync_reg <= lms_meta_reg;
    bms_meta_reg <= i_backplane_output_mode_select;
    bms_sync_reg <= bms_meta_reg;
  end

  // frame edge detect on synchronised pulse
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      fp_prev_reg <= 1'b0;
    end else begin
      fp_prev_reg <= fp_sync_reg;
    end
  end
  assign frame_edge = fp_sync_reg & ~fp_prev_reg;

  ////////////////////////////////////////////////////////////////////////
  // output mode selects captured only while reset is held; the pins are
  // expected to be strapped, so later changes are deliberately ignored
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      local_tristate_mode_reg <= lms_sync_reg;
      backplane_tristate_mode_reg <= bms_sync_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // register writes
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      control_reg <= `CTRL_RESET;
      for (int i = 0; i < 8; i++) begin
        local_input_delay_reg[i] <= `DELAY_RESET;
        backplane_input_delay_reg[i] <= `DELAY_RESET;
        local_output_advance_reg[i] <= `ADV_RESET;
        backplane_output_advance_reg[i] <= `ADV_RESET;
      end
    end else if (i_wr) begin
      if (i_addr == `ADDR_CONTROL) begin
        control_reg <= {10'h000, i_wdata[5:0]};
      end
      for (int i = 0; i < 8; i++) begin
        if (i_addr == `ADDR_LOCAL_DELAY_BASE + 8'(i)) begin
          local_input_delay_reg[i] <= i_wdata[4:0];
        end
        if (i_addr == `ADDR_BACKPLANE_DELAY_BASE + 8'(i)) begin
          backplane_input_delay_reg[i] <= i_wdata[4:0];
        end
        if (i_addr == `ADDR_LOA_BASE + 8'(i)) begin
          local_output_advance_reg[i] <= i_wdata[1:0];
        end
        if (i_addr == `ADDR_BOA_BASE + 8'(i)) begin
          backplane_output_advance_reg[i] <= i_wdata[1:0];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read mux; unmapped addresses read zero
  always_comb begin
    rdata_next = 16'h0000;
    if (i_addr == `ADDR_CONTROL) begin
      rdata_next = control_reg;
    end
    if (i_addr == `ADDR_STATUS) begin
      rdata_next = {10'h000, disc_state, local_tristate_mode_reg,
                    backplane_tristate_mode_reg, drive_sync_reg};
    end
    for (int i = 0; i < 8; i++) begin
      if (i_addr == `ADDR_LOCAL_DELAY_BASE + 8'(i)) begin
        rdata_next = {11'h000, local_input_delay_reg[i]};
      end
      if (i_addr == `ADDR_BACKPLANE_DELAY_BASE + 8'(i)) begin
        rdata_next = {11'h000, backplane_input_delay_reg[i]};
      end
      if (i_addr == `ADDR_LOA_BASE + 8'(i)) begin
        rdata_next = {14'h0, local_output_advance_reg[i]};
      end
      if (i_addr == `ADDR_BOA_BASE + 8'(i)) begin
        rdata_next = {14'h0, backplane_output_advance_reg[i]};
      end
    end
  end

  // read data stands one cycle after the strobe only
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      o_rdata <= 16'h0000;
    end else if (i_rd) begin
      o_rdata <= rdata_next;
    end else begin
      o_rdata <= 16'h0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // discriminator mode decode
  always_comb begin
    if (!control_reg[`CTRL_DISC_EN_BIT]) begin
      disc_state = tdm_timing_pkg::DISC_OFF;
    end else if (control_reg[`CTRL_DISC_MODE_LSB +: 3] ==
                 `DISC_MODE_FULL) begin
      disc_state = tdm_timing_pkg::DISC_FULL;
    end else begin
      // reserved codes behave as the low-frequency setting
      disc_state = tdm_timing_pkg::DISC_LOW_ONLY;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      o_disc_active <= 1'b0;
      o_disc_high_freq <= 1'b0;
    end else begin
      unique case (disc_state)
        tdm_timing_pkg::DISC_OFF: begin
          o_disc_active <= 1'b0;
          o_disc_high_freq <= 1'b0;
        end
        tdm_timing_pkg::DISC_LOW_ONLY: begin
          o_disc_active <= 1'b1;
          o_disc_high_freq <= 1'b0;
        end
        tdm_timing_pkg::DISC_FULL: begin
          o_disc_active <= 1'b1;
          o_disc_high_freq <= 1'b1;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // shadow settings to frame-aligned holders
  always_comb begin
    lcfg.frame_edge = frame_edge;
    bcfg.frame_edge = frame_edge;
    for (int i = 0; i < 8; i++) begin
      lcfg.shadow[i].delay = local_input_delay_reg[i];
      lcfg.shadow[i].advance = local_output_advance_reg[i];
      bcfg.shadow[i].delay = backplane_input_delay_reg[i];
      bcfg.shadow[i].advance = backplane_output_advance_reg[i];
    end
  end

  frame_cfg_latch u_local_latch (
    .i_ref_clk(i_ref_clk),
    .i_reset(i_reset),
    .cfg(lcfg.holder)
  );

  frame_cfg_latch u_backplane_latch (
    .i_ref_clk(i_ref_clk),
    .i_reset(i_reset),
    .cfg(bcfg.holder)
  );

  ////////////////////////////////////////////////////////////////////////
  // per-stream timing outputs from active settings
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      o_local_whole_delay <= 24'h000000;
      o_local_quarter_delay <= 16'h0000;
      o_backplane_whole_delay <= 24'h000000;
      o_backplane_quarter_delay <= 16'h0000;
      o_local_advance <= 16'h0000;
      o_backplane_advance <= 16'h0000;
    end else begin
      for (int i = 0; i < 8; i++) begin
        // whole bits and leftover quarter/sample code per stream
        o_local_whole_delay[i*3 +: 3] <=
          whole_bits(lcfg.active[i].delay,
                     control_reg[`CTRL_SAMPLE_MODE_BIT]);
        o_local_quarter_delay[i*2 +: 2] <=
          control_reg[`CTRL_SAMPLE_MODE_BIT] ?
          sample_point(lcfg.active[i].delay, 1'b1) :
          lcfg.active[i].delay[1:0];
        o_backplane_whole_delay[i*3 +: 3] <=
          whole_bits(bcfg.active[i].delay,
                     control_reg[`CTRL_SAMPLE_MODE_BIT]);
        o_backplane_quarter_delay[i*2 +: 2] <=
          control_reg[`CTRL_SAMPLE_MODE_BIT] ?
          sample_point(bcfg.active[i].delay, 1'b1) :
          bcfg.active[i].delay[1:0];
        o_local_advance[i*2 +: 2] <= lcfg.active[i].advance;
        o_backplane_advance[i*2 +: 2] <= bcfg.active[i].advance;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // output enable priority; reset wins over everything
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      // during reset use the live synchronised selects
      o_local_output_streams_oe_n <= {8{lms_sync_reg}};
      o_local_force_high <= {8{~lms_sync_reg}};
      o_backplane_output_streams_oe_n <= {8{bms_sync_reg}};
      o_backplane_force_high <= {8{~bms_sync_reg}};
    end else begin
      for (int i = 0; i < 8; i++) begin
        if (drive_ok(drive_sync_reg, control_reg[`CTRL_STANDBY_BIT],
                     i_local_channel_output_enable[i])) begin
          o_local_output_streams_oe_n[i] <= 1'b0;
          o_local_force_high[i] <= 1'b0;
        end else begin
          o_local_output_streams_oe_n[i] <= local_tristate_mode_reg;
          o_local_force_high[i] <= ~local_tristate_mode_reg;
        end
        if (drive_ok(drive_sync_reg, control_reg[`CTRL_STANDBY_BIT],
                     i_backplane_channel_output_enable[i])) begin
          o_backplane_output_streams_oe_n[i] <= 1'b0;
          o_backplane_force_high[i] <= 1'b0;
        end else begin
          o_backplane_output_streams_oe_n[i] <= backplane_tristate_mode_reg;
          o_backplane_force_high[i] <= ~backplane_tristate_mode_reg;
        end
      end
    end
  end

endmodule

// File: src/tdm_timing_defines.svh
`ifndef TDM_TIMING_DEFINES_SVH
`define TDM_TIMING_DEFINES_SVH

// register offsets (word addresses on the plain port)
`define ADDR_CONTROL 8'h00
`define ADDR_LOCAL_DELAY_BASE 8'h10
`define ADDR_BACKPLANE_DELAY_BASE 8'h18
`define ADDR_LOA_BASE 8'h20
`define ADDR_BOA_BASE 8'h28
`define ADDR_STATUS 8'h30

// control register field positions
`define CTRL_DISC_EN_BIT 0
`define CTRL_DISC_MODE_LSB 1
`define CTRL_SAMPLE_MODE_BIT 4
`define CTRL_STANDBY_BIT 5

// reset values
`define CTRL_RESET 16'h0000
`define DELAY_RESET 5'h00
`define ADV_RESET 2'h0

// discriminator mode codes
`define DISC_MODE_LOW 3'h0
`define DISC_MODE_FULL 3'h7

// sampling point code for 3/4 bit (default)
`define SAMPLE_3Q 2'h0

// quarter-bit ticks per bit
`define QUARTERS_PER_BIT 4

`endif

// File: src/tdm_timing_pkg.sv
package tdm_timing_pkg;

  // effective discriminator behaviour
  typedef enum logic [2:0] {
    DISC_OFF = 3'b001,
    DISC_LOW_ONLY = 3'b010,
    DISC_FULL = 3'b100
  } disc_state_t;

  // per-stream timing settings carried between modules
  typedef struct packed {
    logic [4:0] delay;
    logic [1:0] advance;
  } stream_cfg_t;

endpackage

// File: src/stream_timing_if.sv
`timescale 1ns/1ps
// shadow settings for one port of eight streams, applied at frame edge
interface stream_timing_if;
  logic frame_edge;
  tdm_timing_pkg::stream_cfg_t shadow [8];
  tdm_timing_pkg::stream_cfg_t active [8];
  modport owner (output frame_edge, output shadow, input active);
  modport holder (input frame_edge, input shadow, output active);
endinterface

// File: src/frame_cfg_latch.sv
`timescale 1ns/1ps
`include "tdm_timing_defines.svh"

// holds working copies of the stream settings; updates only at a frame
// edge so no frame is ever partly shifted
module frame_cfg_latch (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_reset,
  // settings
  stream_timing_if.holder cfg
);

  ////////////////////////////////////////////////////////////////////////
  // copy shadow to active on frame boundary
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      for (int i = 0; i < 8; i++) begin
        cfg.active[i].delay <= `DELAY_RESET;
        cfg.active[i].advance <= `ADV_RESET;
      end
    end else if (cfg.frame_edge) begin
      cfg.active <= cfg.shadow;
    end
  end

endmodule

// File: tb/tdm_port_monitor.sv
`timescale 1ns/1ps
// watches the timing block pins for enable and frame hazards
module tdm_port_monitor (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_reset,
  // register port and pins
  input wire logic i_rd,
  input wire logic [15:0] o_rdata,
  input wire logic i_master_frame_pulse,
  input wire logic i_output_drive_input,
  input wire logic [7:0] i_local_channel_output_enable,
  input wire logic [7:0] i_backplane_channel_output_enable,
  // outputs under watch
  input wire logic o_disc_active,
  input wire logic o_disc_high_freq,
  input wire logic [15:0] o_local_advance,
  input wire logic [15:0] o_backplane_advance,
  input wire logic [7:0] o_local_output_streams_oe_n,
  input wire logic [7:0] o_local_force_high,
  input wire logic [7:0] o_backplane_output_streams_oe_n,
  input wire logic [7:0] o_backplane_force_high
);
  ////////////////////////////////////////////////////////////////////////////
  // reset long enough for the strap synchronisers to settle
  sequence reset_held;
    i_reset [*3];
  endsequence
  // pulse low long enough that no frame edge is still in the sync
  sequence frame_quiet;
    !i_master_frame_pulse [*6];
  endsequence
  ////////////////////////////////////////////////////////////////////////////
  a_reset_idle: assert property (@(posedge i_ref_clk)
    reset_held |=> &(o_local_output_streams_oe_n | o_local_force_high)
    && &(o_backplane_output_streams_oe_n | o_backplane_force_high))
    else $error("stream driven during reset");
  a_reset_clear: assert property (@(posedge i_ref_clk)
    i_reset |=> o_rdata == 16'h0000 && !o_disc_active && !o_disc_high_freq)
    else $error("state not cleared by reset");
  a_rdata_idle: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    !i_rd |=> o_rdata == 16'h0000)
    else $error("read data outside its cycle");
  a_disc_mode_gated: assert property (@(posedge i_ref_clk)
    disable iff (i_reset) o_disc_high_freq |-> o_disc_active)
    else $error("mode acted while discriminator off");
  a_local_bistate: assert property (@(posedge i_ref_clk)
    disable iff (i_reset)
    |o_local_force_high |-> o_local_output_streams_oe_n == 8'h00)
    else $error("local bi-state port released");
  a_bp_bistate: assert property (@(posedge i_ref_clk)
    disable iff (i_reset)
    |o_backplane_force_high |-> o_backplane_output_streams_oe_n == 8'h00)
    else $error("backplane bi-state port released");
  a_drive_pin_gate: assert property (@(posedge i_ref_clk)
    disable iff (i_reset) !i_output_drive_input [*4] |->
    &(o_local_output_streams_oe_n | o_local_force_high)
    && &(o_backplane_output_streams_oe_n | o_backplane_force_high))
    else $error("data driven with drive pin low");
  a_chan_needs_en: assert property (@(posedge i_ref_clk)
    disable iff (i_reset)
    (~o_local_output_streams_oe_n & ~o_local_force_high
    & ~$past(i_local_channel_output_enable)) == 8'h00
    && (~o_backplane_output_streams_oe_n & ~o_backplane_force_high
    & ~$past(i_backplane_channel_output_enable)) == 8'h00)
    else $error("disabled channel driven");
  a_adv_at_frame: assert property (@(posedge i_ref_clk)
    disable iff (i_reset) frame_quiet |->
    $stable(o_local_advance) && $stable(o_backplane_advance))
    else $error("advance moved without frame edge");
endmodule

bind tdm_port_timing tdm_port_monitor mon (
  .i_ref_clk(i_ref_clk), .i_reset(i_reset), .i_rd(i_rd), .o_rdata(o_rdata),
  .i_master_frame_pulse(i_master_frame_pulse),
  .i_output_drive_input(i_output_drive_input),
  .i_local_channel_output_enable(i_local_channel_output_enable),
  .i_backplane_channel_output_enable(i_backplane_channel_output_enable),
  .o_disc_active(o_disc_active), .o_disc_high_freq(o_disc_high_freq),
  .o_local_advance(o_local_advance),
  .o_backplane_advance(o_backplane_advance),
  .o_local_output_streams_oe_n(o_local_output_streams_oe_n),
  .o_local_force_high(o_local_force_high),
  .o_backplane_output_streams_oe_n(o_backplane_output_streams_oe_n),
  .o_backplane_force_high(o_backplane_force_high));

// File: tb/frame_source.sv
`timescale 1ns/1ps
// far side timing master: emits one frame pulse on request
module frame_source (
  // clock
  input wire logic i_ref_clk,
  // request a frame boundary
  input wire logic i_fire,
  // pulse toward the switch
  output logic o_pulse
);
  logic [1:0] cnt_reg = 2'h0; // pulse length counter
  // two cycles wide so the two-stage sync never misses it
  always_ff @(posedge i_ref_clk) begin
    if (i_fire) begin
      cnt_reg <= 2'h2;
    end else if (cnt_reg != 2'h0) begin
      cnt_reg <= cnt_reg - 2'h1;
    end
  end
  assign o_pulse = (cnt_reg != 2'h0);
endmodule

// File: tb/tb.sv
`timescale 1ns/1ps
module tb;
  logic i_ref_clk = 1'b0;
  logic i_reset = 1'b1;
  logic [7:0] i_addr = 8'h00;
  logic [15:0] i_wdata = 16'h0000;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic fire = 1'b0;
  logic drive = 1'b0;
  logic lsel = 1'b1;
  logic bsel = 1'b0;
  logic [7:0] len = 8'h00;
  logic [7:0] ben = 8'h00;
  logic pulse, da, dh;
  logic [15:0] o_rdata, la, ba, lq, bq;
  logic [23:0] lw, bw;
  logic [7:0] loe, lfh, boe, bfh;
  int fails = 0;
  int comparisons = 0;
  // control words, expected discriminator outputs and status per mode
  logic [15:0] cv [4] = '{16'h000E, 16'h0001, 16'h0007, 16'h000F};
  logic [1:0] dv [4] = '{2'b00, 2'b10, 2'b10, 2'b11};
  logic [15:0] sv [4] = '{16'h000C, 16'h0014, 16'h0014, 16'h0024};

  always #50 i_ref_clk = ~i_ref_clk;

  frame_source fs (.i_ref_clk(i_ref_clk), .i_fire(fire), .o_pulse(pulse));

  tdm_port_timing dut (.i_ref_clk(i_ref_clk), .i_reset(i_reset),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .o_rdata(o_rdata), .i_master_frame_pulse(pulse),
    .i_output_drive_input(drive), .i_local_output_mode_select(lsel),
    .i_backplane_output_mode_select(bsel),
    .i_local_channel_output_enable(len),
    .i_backplane_channel_output_enable(ben),
    .o_disc_active(da), .o_disc_high_freq(dh),
    .o_local_whole_delay(lw), .o_local_quarter_delay(lq),
    .o_backplane_whole_delay(bw), .o_backplane_quarter_delay(bq),
    .o_local_advance(la), .o_backplane_advance(ba),
    .o_local_output_streams_oe_n(loe), .o_local_force_high(lfh),
    .o_backplane_output_streams_oe_n(boe), .o_backplane_force_high(bfh));

  ////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [23:0] e,
                     input logic [23:0] g);
    comparisons++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge i_ref_clk);
    #1;
  endtask
  // one-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge i_ref_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_ref_clk);
    i_wr <= 1'b0;
  endtask
  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    @(posedge i_ref_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_ref_clk);
    i_rd <= 1'b0;
    #1;
    chk("rdata", 24'(e), 24'(o_rdata));
  endtask
  task automatic pins(input logic d, input logic [7:0] l, input logic [7:0] b);
    @(posedge i_ref_clk);
    drive <= d;
    len <= l;
    ben <= b;
    idle(4);
  endtask
  // reset with given straps; straps flip at release, so the captured
  // port mode is seen to ignore later pin changes
  task automatic do_reset(input logic l, input logic b);
    @(posedge i_ref_clk);
    i_reset <= 1'b1;
    lsel <= l;
    bsel <= b;
    repeat (4) @(posedge i_ref_clk);
    i_reset <= 1'b0;
    lsel <= ~l;
    bsel <= ~b;
    idle(1);
  endtask
  task automatic oe_chk(input logic [7:0] a, b, c, d);
    chk("l_oe_n", 24'(a), 24'(loe));
    chk("l_high", 24'(b), 24'(lfh));
    chk("b_oe_n", 24'(c), 24'(boe));
    chk("b_high", 24'(d), 24'(bfh));
  endtask
  // frame edge lands two cycles after the pulse rises; timing outputs update two cycles after that
  task automatic frame();
    @(posedge i_ref_clk);
    fire <= 1'b1;
    @(posedge i_ref_clk);
    fire <= 1'b0;
    idle(8);
  endtask
  task automatic dly_chk();
    chk("l_whole", 24'h000180, lw);
    chk("l_qtr", 24'h000030, 24'(lq));
    chk("b_whole", 24'h200000, bw);
    chk("b_qtr", 24'h008000, 24'(bq));
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #(100 * 3000);
    fails++;
    wrap_up();
  end

  initial begin
    do_reset(1'b1, 1'b0);
    oe_chk(8'hFF, 8'h00, 8'h00, 8'hFF);
    chk("disc", 24'h0, 24'({da, dh}));
    rd(8'h00, 16'h0000);
    rd(8'h30, 16'h000C);
    rd(8'h3F, 16'h0000);
    rd(8'h10, 16'h0000);
    chk("point", 24'h0, 24'(lq));
    for (int k = 0; k < 4; k++) begin
      wr(8'h00, cv[k]);
      idle(2);
      chk("disc", 24'(dv[k]), 24'({da, dh}));
      rd(8'h30, sv[k]);
    end
    wr(8'h12, 16'h001B);
    wr(8'h1F, 16'h0006);
    wr(8'h23, 16'h0003);
    wr(8'h28, 16'h0002);
    rd(8'h12, 16'h001B);
    idle(2);
    chk("l_whole", 24'h0, lw);
    chk("l_adv", 24'h0, 24'(la));
    frame();
    dly_chk();
    chk("l_adv", 24'h0000C0, 24'(la));
    chk("b_adv", 24'h000002, 24'(ba));
    wr(8'h00, 16'h001F);
    idle(2);
    dly_chk();
    wr(8'h00, 16'h003F);
    pins(1'b1, 8'h0F, 8'hF0);
    oe_chk(8'hF0, 8'h00, 8'h00, 8'h0F);
    rd(8'h30, 16'h0025);
    pins(1'b0, 8'h0F, 8'hF0);
    oe_chk(8'hFF, 8'h00, 8'h00, 8'hFF);
    pins(1'b1, 8'hFF, 8'h00);
    oe_chk(8'h00, 8'h00, 8'h00, 8'hFF);
    wr(8'h00, 16'h001F);
    idle(2);
    oe_chk(8'hFF, 8'h00, 8'h00, 8'hFF);
    do_reset(1'b0, 1'b1);
    wr(8'h00, 16'h0021);
    pins(1'b1, 8'h00, 8'h00);
    oe_chk(8'h00, 8'hFF, 8'hFF, 8'h00);
    chk("l_adv", 24'h0, 24'(la));
    wrap_up();
  end
endmodule
